// file: dca_pkg.sv
/*
 * Shared constants for the command/address pin front end of an eight-bank
 * DRAM device: pin widths, command codes, crossing event codes, mode register
 * fields and reset values.
 * Assumes nothing of its surroundings; imported whole by every design file.
 */
package dca_pkg;

	////////////////////////////////////////////////////////////////////////
	// Pin and storage widths
	localparam int BA_W    = 3;
	localparam int ADDR_W  = 14;
	localparam int COL_W   = 10;
	localparam int DATA_W  = 8;
	localparam int NBANK   = 8;
	localparam int NMR     = 4;
	localparam int EV_W    = 4;
	localparam int BEAT_W  = 4;

	////////////////////////////////////////////////////////////////////////
	// Command codes on {row strobe, column strobe, write enable}, active low
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_ZQ  = 3'h6;
	localparam logic [2:0] CMD_NOP = 3'h7;

	// Events sent across the clock boundary; low codes equal command codes
	localparam logic [EV_W-1:0] EV_MRS = 4'h0;
	localparam logic [EV_W-1:0] EV_REF = 4'h1;
	localparam logic [EV_W-1:0] EV_PRE = 4'h2;
	localparam logic [EV_W-1:0] EV_ACT = 4'h3;
	localparam logic [EV_W-1:0] EV_WR  = 4'h4;
	localparam logic [EV_W-1:0] EV_RD  = 4'h5;
	localparam logic [EV_W-1:0] EV_PDE = 4'h8;
	localparam logic [EV_W-1:0] EV_SRE = 4'h9;

	////////////////////////////////////////////////////////////////////////
	// Address bit positions with special meaning
	localparam int AP_BIT  = 10;
	localparam int BC_BIT  = 12;

	// Mode register fields
	localparam int             MR1_TDQS_BIT = 11;
	localparam logic [ADDR_W-1:0] MR1_RTT_NOM_MASK = 14'h0244;
	localparam logic [ADDR_W-1:0] MR2_RTT_WR_MASK  = 14'h0600;
	localparam logic [1:0]     MR0_BL_FIXED8 = 2'h0;
	localparam logic [1:0]     MR0_BL_OTF    = 2'h1;
	localparam logic [1:0]     MR0_BL_FIXED4 = 2'h2;
	localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;

	// Beat counts for full and chopped bursts
	localparam logic [BEAT_W-1:0] BEATS_BL8 = 4'h8;
	localparam logic [BEAT_W-1:0] BEATS_BC4 = 4'h4;

	typedef enum logic [3:0] {
		PW_ON  = 4'h1,
		PW_APD = 4'h2,
		PW_PPD = 4'h4,
		PW_SR  = 4'h8
	} dca_pwr_e;

endpackage : dca_pkg

// file: dca_sync2.sv
/*
 * Two-flop level synchroniser with asynchronous clear.
 * Assumes the input is a level that stays put for several destination edges.
 */
`timescale 1ns/1ps
module dca_sync2 import dca_pkg::*; #(
	parameter int W = 1
) (
	// Destination domain
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule : dca_sync2

// file: dca_cmd_front.sv
/*
 * Command, address and control pin front end of an eight-bank DRAM device.
 * The link side runs on the rising edge of the true clock of the differential
 * pair; the core side on core_clk. Assumes the controller keeps clock enable
 * high through accesses and keeps the reset pin high in normal operation.
 */
`timescale 1ns/1ps

// Contract
// - Sample address and control on rising clock
// - Clock enable gates clocks, buffers, drivers
// - Clock enable fall picks power-down kind
// - Self-refresh exit detected without link clock
// - Self-refresh disables command and address buffers
// - Chip select high masks the command
// - Strobes plus chip select decode command
// - Termination enable turns on line termination
// - Termination ignored in self-refresh or disabled
// - Masked write beats are discarded
// - Mode register one selects mask or strobe
// - Bank address picks the target bank
// - Bank address picks mode register, address opcode
// - Fourteen-bit row, ten-bit column address
// - Access auto-precharge bit closes bank after
// - Precharge bit picks one or all banks
// - Burst chop bit low chops the burst
// - Reset pin clears device asynchronously
// - Bursts are eight beats or chopped four
// - Strobe mode mirrors termination, else mask
module dca_cmd_front import dca_pkg::*; (
	// Core clock and reset
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// Device pins
	input  wire logic              diff_clock_pair_t,
	input  wire logic              rst_pin_n,
	input  wire logic              cke,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic [BA_W-1:0]   bank_select,
	input  wire logic [ADDR_W-1:0] row_col_address,
	input  wire logic              termination_enable,
	// Write beats from the data path, core clock
	input  wire logic              beat_valid,
	input  wire logic [DATA_W-1:0] beat_data,
	input  wire logic              write_data_mask,
	// Power and buffer state
	output logic                   int_clk_en,
	output logic                   cmd_buf_en,
	output logic                   out_drv_en,
	output logic                   self_refresh,
	output logic [3:0]             pwr_state,
	// Termination
	output logic                   term_on,
	output logic                   term_strobe_on,
	output logic                   tdqs_mode,
	// Bank state and accesses
	output logic [NBANK-1:0]       bank_open,
	output logic                   acc_valid,
	output logic                   acc_write,
	output logic [BA_W-1:0]        acc_bank,
	output logic [ADDR_W-1:0]      acc_row,
	output logic [COL_W-1:0]       acc_col,
	output logic                   acc_chop,
	output logic                   acc_autopre,
	output logic                   refresh_pulse,
	// Accepted write data
	output logic                   store_valid,
	output logic [DATA_W-1:0]      store_data,
	output logic                   wr_burst_busy
);

	function automatic logic [NBANK-1:0] bank_hot(input logic [BA_W-1:0] b);
		bank_hot = NBANK'(1) << b;
	endfunction : bank_hot

	////////////////////////////////////////////////////////////////////////
	// Link domain: pin capture on the rising true clock

	logic              cke_l_reg;
	logic              cke_prev_reg;
	logic              odt_l_reg;
	logic              cs_n_reg;
	logic [2:0]        code_reg;
	logic [BA_W-1:0]   ba_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic              sr_l;
	logic              ack_l;

	dca_sync2 #(.W(1)) u_sr_to_link (
		.clk   (diff_clock_pair_t),
		.rst_n (rst_pin_n),
		.d     (self_refresh),
		.q     (sr_l)
	);

	// Clock enable and termination buffers stay live in self-refresh
	always_ff @(posedge diff_clock_pair_t or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			cke_l_reg    <= 1'b0;
			cke_prev_reg <= 1'b0;
			odt_l_reg    <= 1'b0;
		end else begin
			cke_l_reg    <= cke;
			cke_prev_reg <= cke_l_reg;
			odt_l_reg    <= termination_enable;
		end
	end

	always_ff @(posedge diff_clock_pair_t or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			cs_n_reg <= 1'b1;
			code_reg <= CMD_NOP;
			ba_reg   <= '0;
			addr_reg <= '0;
		end else if (!sr_l) begin
			cs_n_reg <= cs_n;
			code_reg <= {ras_n, cas_n, we_n};
			ba_reg   <= bank_select;
			addr_reg <= row_col_address;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link domain: decode and hand over to the core by toggle handshake

	logic              cmd_live;
	logic              cke_fall;
	logic              ev_fire;
	logic [EV_W-1:0]   ev_kind;
	logic              req_tgl_reg;
	logic [EV_W-1:0]   pay_kind_reg;
	logic [BA_W-1:0]   pay_ba_reg;
	logic [ADDR_W-1:0] pay_addr_reg;

	always_comb begin
		cmd_live = cke_prev_reg && cke_l_reg && !cs_n_reg;
		cke_fall = cke_prev_reg && !cke_l_reg;
		ev_kind  = {1'b0, code_reg};
		ev_fire  = 1'b0;
		if (cke_fall) begin
			ev_fire = 1'b1;
			if (!cs_n_reg && code_reg == CMD_REF)
				ev_kind = EV_SRE;
			else
				ev_kind = EV_PDE;
		end else if (cmd_live && code_reg != CMD_NOP && code_reg != CMD_ZQ) begin
			ev_fire = 1'b1;
		end
	end

	// A command that arrives while the previous one is still in flight is
	// dropped; the controller spaces commands far wider than the round trip.
	always_ff @(posedge diff_clock_pair_t or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			req_tgl_reg  <= 1'b0;
			pay_kind_reg <= EV_REF;
			pay_ba_reg   <= '0;
			pay_addr_reg <= '0;
		end else if (ev_fire && (req_tgl_reg == ack_l)) begin
			req_tgl_reg  <= ~req_tgl_reg;
			pay_kind_reg <= ev_kind;
			pay_ba_reg   <= ba_reg;
			pay_addr_reg <= addr_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: crossings

	logic req_c;
	logic cke_c;
	logic odt_c;
	logic ack_tgl_reg;
	logic ev_new;

	dca_sync2 #(.W(1)) u_req_to_core (
		.clk   (core_clk),
		.rst_n (rst_pin_n),
		.d     (req_tgl_reg),
		.q     (req_c)
	);

	// Straight from the pin, so exit is seen even with the link clock halted
	dca_sync2 #(.W(1)) u_cke_to_core (
		.clk   (core_clk),
		.rst_n (rst_pin_n),
		.d     (cke),
		.q     (cke_c)
	);

	dca_sync2 #(.W(1)) u_odt_to_core (
		.clk   (core_clk),
		.rst_n (rst_pin_n),
		.d     (odt_l_reg),
		.q     (odt_c)
	);

	dca_sync2 #(.W(1)) u_ack_to_link (
		.clk   (diff_clock_pair_t),
		.rst_n (rst_pin_n),
		.d     (ack_tgl_reg),
		.q     (ack_l)
	);

	assign ev_new = req_c ^ ack_tgl_reg;

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n)
			ack_tgl_reg <= 1'b0;
		else
			// Keeps tracking under core reset so no stale event survives it
			ack_tgl_reg <= req_c;
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: mode registers

	logic [ADDR_W-1:0] mr_reg [NMR];
	logic              odt_allowed;
	logic              otf_en;
	logic              fixed_bc4;

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			for (int i = 0; i < NMR; i++)
				mr_reg[i] <= MR_RESET;
		end else if (!resetn) begin
			for (int i = 0; i < NMR; i++)
				mr_reg[i] <= MR_RESET;
		end else if (ev_new && pay_kind_reg == EV_MRS && !pay_ba_reg[2]) begin
			mr_reg[pay_ba_reg[1:0]] <= pay_addr_reg;
		end
	end

	always_comb begin
		odt_allowed = |(mr_reg[1] & MR1_RTT_NOM_MASK) ||
		              |(mr_reg[2] & MR2_RTT_WR_MASK);
		otf_en      = mr_reg[0][1:0] == MR0_BL_OTF;
		fixed_bc4   = mr_reg[0][1:0] == MR0_BL_FIXED4;
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: power state

	dca_pwr_e pwr_reg;
	dca_pwr_e pwr_next;

	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
		PW_ON: begin
			if (ev_new && pay_kind_reg == EV_SRE && bank_open == '0)
				pwr_next = PW_SR;
			else if (ev_new && (pay_kind_reg == EV_SRE ||
			                    pay_kind_reg == EV_PDE))
				pwr_next = (bank_open == '0) ? PW_PPD : PW_APD;
		end
		PW_APD, PW_PPD, PW_SR: begin
			if (cke_c)
				pwr_next = PW_ON;
		end
		default: pwr_next = PW_ON;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n)
			pwr_reg <= PW_ON;
		else if (!resetn)
			pwr_reg <= PW_ON;
		else
			pwr_reg <= pwr_next;
	end

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			int_clk_en     <= 1'b0;
			cmd_buf_en     <= 1'b0;
			out_drv_en     <= 1'b0;
			self_refresh   <= 1'b0;
			pwr_state      <= PW_ON;
			term_on        <= 1'b0;
			term_strobe_on <= 1'b0;
			tdqs_mode      <= 1'b0;
		end else if (!resetn) begin
			int_clk_en     <= 1'b0;
			cmd_buf_en     <= 1'b0;
			out_drv_en     <= 1'b0;
			self_refresh   <= 1'b0;
			pwr_state      <= PW_ON;
			term_on        <= 1'b0;
			term_strobe_on <= 1'b0;
			tdqs_mode      <= 1'b0;
		end else begin
			int_clk_en     <= cke_c;
			out_drv_en     <= cke_c;
			cmd_buf_en     <= cke_c && pwr_next != PW_SR;
			self_refresh   <= pwr_next == PW_SR;
			pwr_state      <= pwr_next;
			term_on        <= odt_c && odt_allowed &&
			                  pwr_next != PW_SR;
			term_strobe_on <= odt_c && odt_allowed && pwr_next != PW_SR &&
			                  mr_reg[1][MR1_TDQS_BIT];
			tdqs_mode      <= mr_reg[1][MR1_TDQS_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: bank tracking and command execution

	logic [ADDR_W-1:0] open_row [NBANK];
	logic              chop_now;
	logic [NBANK-1:0]  ap_close;
	logic              is_acc;

	always_comb begin
		is_acc   = ev_new && (pay_kind_reg == EV_WR || pay_kind_reg == EV_RD);
		chop_now = fixed_bc4 || (otf_en && !pay_addr_reg[BC_BIT]);
		ap_close = '0;
		if (is_acc && pay_addr_reg[AP_BIT])
			ap_close = bank_hot(pay_ba_reg);
	end

	// Row contents need no reset; a pin reset may lose them
	always_ff @(posedge core_clk) begin
		if (ev_new && pay_kind_reg == EV_ACT)
			open_row[pay_ba_reg] <= pay_addr_reg;
	end

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			bank_open <= '0;
		end else if (!resetn) begin
			bank_open <= '0;
		end else if (ev_new) begin
			case (pay_kind_reg)
			EV_ACT: bank_open <= bank_open | bank_hot(pay_ba_reg);
			EV_PRE: begin
				if (pay_addr_reg[AP_BIT])
					bank_open <= '0;
				else
					bank_open <= bank_open & ~bank_hot(pay_ba_reg);
			end
			EV_WR, EV_RD: bank_open <= bank_open & ~ap_close;
			default: bank_open <= bank_open;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			acc_valid     <= 1'b0;
			acc_write     <= 1'b0;
			acc_bank      <= '0;
			acc_row       <= '0;
			acc_col       <= '0;
			acc_chop      <= 1'b0;
			acc_autopre   <= 1'b0;
			refresh_pulse <= 1'b0;
		end else if (!resetn) begin
			acc_valid     <= 1'b0;
			acc_write     <= 1'b0;
			acc_bank      <= '0;
			acc_row       <= '0;
			acc_col       <= '0;
			acc_chop      <= 1'b0;
			acc_autopre   <= 1'b0;
			refresh_pulse <= 1'b0;
		end else begin
			acc_valid     <= is_acc;
			refresh_pulse <= ev_new && pay_kind_reg == EV_REF;
			if (is_acc) begin
				acc_write   <= pay_kind_reg == EV_WR;
				acc_bank    <= pay_ba_reg;
				acc_row     <= open_row[pay_ba_reg];
				acc_col     <= pay_addr_reg[COL_W-1:0];
				acc_chop    <= chop_now;
				acc_autopre <= pay_addr_reg[AP_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain: write beats and mask

	logic [BEAT_W-1:0] beats_left_reg;

	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			beats_left_reg <= '0;
		end else if (!resetn) begin
			beats_left_reg <= '0;
		end else if (is_acc && pay_kind_reg == EV_WR) begin
			beats_left_reg <= chop_now ? BEATS_BC4 : BEATS_BL8;
		end else if (beat_valid && beats_left_reg != '0) begin
			beats_left_reg <= beats_left_reg - BEAT_W'(1);
		end
	end

	// In strobe mode the shared pin carries no mask, so no beat is dropped by it
	always_ff @(posedge core_clk or negedge rst_pin_n) begin
		if (!rst_pin_n) begin
			store_valid   <= 1'b0;
			store_data    <= '0;
			wr_burst_busy <= 1'b0;
		end else if (!resetn) begin
			store_valid   <= 1'b0;
			store_data    <= '0;
			wr_burst_busy <= 1'b0;
		end else begin
			store_valid   <= beat_valid && beats_left_reg != '0 &&
			                 !(write_data_mask &&
			                   !mr_reg[1][MR1_TDQS_BIT]);
			store_data    <= beat_data;
			wr_burst_busy <= (is_acc && pay_kind_reg == EV_WR) ||
			                 (beats_left_reg > BEAT_W'(1)) ||
			                 (beats_left_reg == BEAT_W'(1) && !beat_valid);
		end
	end

endmodule : dca_cmd_front

// file: dca_cmd_front_checker.sv
/*
 * Concurrent checks on the core-side outputs of dca_cmd_front.
 * Assumes core_clk is the only sampling clock; bound to every instance.
 */
`timescale 1ns/1ps
module dca_cmd_front_checker import dca_pkg::*; (
	// Clock, resets, pins
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire logic              rst_pin_n,
	input wire logic              cke,
	// Write beats
	input wire logic              beat_valid,
	input wire logic [DATA_W-1:0] beat_data,
	input wire logic              write_data_mask,
	// Observed outputs
	input wire logic              int_clk_en,
	input wire logic              out_drv_en,
	input wire logic              cmd_buf_en,
	input wire logic              self_refresh,
	input wire logic [3:0]        pwr_state,
	input wire logic              term_on,
	input wire logic              term_strobe_on,
	input wire logic              tdqs_mode,
	input wire logic [NBANK-1:0]  bank_open,
	input wire logic              acc_valid,
	input wire logic              acc_write,
	input wire logic [BA_W-1:0]   acc_bank,
	input wire logic              acc_autopre,
	input wire logic              store_valid,
	input wire logic [DATA_W-1:0] store_data,
	input wire logic              wr_burst_busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn || !rst_pin_n);

	////////////////////////////////////////////////////////////////////////
	a_clk_follow_hi: assert property (cke [*5] |-> int_clk_en && out_drv_en)
		else $error("clock enable high not followed");
	a_clk_follow_lo: assert property ((!cke) [*5]
		|-> !int_clk_en && !out_drv_en && !cmd_buf_en)
		else $error("clock enable low not followed");
	a_sr_buf_off: assert property (self_refresh && $past(self_refresh) |-> !cmd_buf_en)
		else $error("command buffers on in self-refresh");
	a_sr_term_off: assert property (self_refresh && $past(self_refresh) |-> !term_on && !term_strobe_on)
		else $error("termination on in self-refresh");
	a_strobe_mode: assert property (term_strobe_on |-> term_on && tdqs_mode)
		else $error("strobe termination without its mode");
	a_mask_drop: assert property (beat_valid && write_data_mask && !tdqs_mode |=> !store_valid)
		else $error("masked beat stored");
	a_beat_store: assert property (beat_valid && !write_data_mask
		&& wr_burst_busy |=> store_valid && store_data == $past(beat_data))
		else $error("beat not stored intact");
	a_no_burst: assert property (!wr_burst_busy && !acc_valid |=> !store_valid)
		else $error("beat stored with no burst");
	a_autopre_close: assert property (acc_valid && acc_autopre |-> !bank_open[acc_bank])
		else $error("bank left open after auto-precharge");
	a_sr_exit: assert property (self_refresh && cke |-> ##[1:6] pwr_state == 4'h1)
		else $error("self-refresh exit late");
	a_pwr_onehot: assert property ($onehot(pwr_state))
		else $error("power state not one-hot");

	c_write: cover property (acc_valid && acc_write);
	c_self_ref: cover property (self_refresh);
	c_strobe_beat: cover property (beat_valid && write_data_mask && tdqs_mode);
	c_strobe_term: cover property (term_strobe_on);
endmodule : dca_cmd_front_checker

bind dca_cmd_front dca_cmd_front_checker u_chk (.core_clk, .resetn, .rst_pin_n,
	.cke, .beat_valid, .beat_data, .write_data_mask, .int_clk_en, .out_drv_en,
	.cmd_buf_en, .self_refresh, .pwr_state, .term_on, .term_strobe_on,
	.tdqs_mode, .bank_open, .acc_valid, .acc_write, .acc_bank, .acc_autopre,
	.store_valid, .store_data, .wr_burst_busy);

// file: dca_ctl_model.sv
/*
 * Behavioural memory controller: link clock, reset pin, clock enable,
 * command, address and termination request. Driven by task calls from
 * the bench; chip select, command, address and termination pins change only after a falling link edge.
 */
`timescale 1ns/1ps
module dca_ctl_model import dca_pkg::*; (
	// Link pins
	output logic              lclk,
	output logic              rst_pin_n,
	output logic              cke,
	output logic              cs_n,
	output logic [2:0]        cmd_n,
	output logic [BA_W-1:0]   bank,
	output logic [ADDR_W-1:0] addr,
	output logic              term_req
);
	logic run;

	initial begin
		{rst_pin_n, cke, cs_n, cmd_n, term_req, run} = 8'h3D;
		bank = '0;
		addr = '0;
		lclk = 1'b0;
		#1.3;
		forever #7.5 lclk = run ? ~lclk : 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Clock enable stays low until the reset pin is released
	task up;
		rst_pin_n = 1'b1;
		repeat (2) @(negedge lclk);
		cke = 1'b1;
		repeat (4) @(negedge lclk);
	endtask : up

	task pin(input logic v);
		rst_pin_n = v;
	endtask : pin

	// Idle bank and address pins show the inverse so a stale value is never mistaken
	task automatic issue(input logic sel_n, input logic [2:0] c,
			input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a);
		@(negedge lclk);
		cs_n = sel_n;
		cmd_n = c;
		bank = b;
		addr = a;
		@(negedge lclk);
		cs_n = 1'b1;
		cmd_n = CMD_NOP;
		bank = ~b;
		addr = ~a;
		repeat (6) @(negedge lclk);
	endtask : issue

	task automatic enter(input logic [2:0] c);
		@(negedge lclk);
		cke = 1'b0;
		cs_n = 1'b0;
		cmd_n = c;
		@(negedge lclk);
		cs_n = 1'b1;
		cmd_n = CMD_NOP;
		repeat (3) @(negedge lclk);
		run = (c != CMD_REF);
		#80;
	endtask : enter

	// Self-refresh exit happens with the link clock still stopped
	task leave;
		if (run)
			@(negedge lclk);
		cke = 1'b1;
		#60;
		run = 1'b1;
		repeat (4) @(negedge lclk);
	endtask : leave

	task term_set(input logic v);
		@(negedge lclk);
		term_req = v;
		repeat (4) @(negedge lclk);
		#40;
	endtask : term_set
endmodule : dca_ctl_model

// file: dca_cmd_front_tb.sv
/*
 * Self-checking bench for dca_cmd_front with a controller model.
 * Assumes the checker file is compiled alongside for its bind.
 */
`timescale 1ns/1ps
module dca_cmd_front_tb import dca_pkg::*; ;
	logic                core_clk, resetn, beat_valid, write_data_mask;
	logic [DATA_W-1:0]   beat_data, store_data;
	wire logic           lclk, rst_pin_n, cke, cs_n, term_req;
	wire logic [2:0]     cmd_n;
	wire logic [BA_W-1:0] bank;
	wire logic [ADDR_W-1:0] addr;
	logic                int_clk_en, cmd_buf_en, out_drv_en, self_refresh;
	logic                term_on, term_strobe_on, tdqs_mode, acc_valid;
	logic                acc_write, acc_chop, acc_autopre, refresh_pulse;
	logic                store_valid, wr_burst_busy;
	logic [3:0]          pwr_state;
	logic [NBANK-1:0]    bank_open;
	logic [BA_W-1:0]     acc_bank, b;
	logic [ADDR_W-1:0]   acc_row, r;
	logic [COL_W-1:0]    acc_col;
	logic [31:0]         rnd;
	logic [31:0]         acc_q[$];
	logic [7:0]          st_q[$];
	int                  n_fail, check_count, n_ref;

	dca_ctl_model ctl (.lclk, .rst_pin_n, .cke, .cs_n, .cmd_n, .bank, .addr,
		.term_req);
	dca_cmd_front dut (.core_clk, .resetn, .diff_clock_pair_t(lclk),
		.rst_pin_n, .cke, .cs_n, .ras_n(cmd_n[2]), .cas_n(cmd_n[1]),
		.we_n(cmd_n[0]), .bank_select(bank), .row_col_address(addr),
		.termination_enable(term_req), .beat_valid, .beat_data,
		.write_data_mask, .int_clk_en, .cmd_buf_en, .out_drv_en,
		.self_refresh, .pwr_state, .term_on, .term_strobe_on, .tdqs_mode,
		.bank_open, .acc_valid, .acc_write, .acc_bank, .acc_row, .acc_col,
		.acc_chop, .acc_autopre, .refresh_pulse, .store_valid, .store_data,
		.wr_burst_busy);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task test_done;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// Masked beats still use up a slot of the burst
	task automatic beats(input int n, input int lim, input int mpos,
			input logic drop);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk);
			rnd = lfsr(rnd);
			beat_valid = 1'b1;
			beat_data = rnd[7:0];
			write_data_mask = (i == mpos);
			if (i < lim && !(drop && i == mpos))
				st_q.push_back(rnd[7:0]);
		end
		@(negedge core_clk);
		beat_valid = 1'b0;
		write_data_mask = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : beats

	task automatic access(input logic [2:0] c, input logic ch, input logic ap,
			input logic [BA_W-1:0] bb, input logic [ADDR_W-1:0] rr);
		logic [COL_W-1:0] col;
		rnd = lfsr(rnd);
		col = rnd[9:0];
		acc_q.push_back({2'b00, c == CMD_WR, bb, rr, col, ch, ap});
		ctl.issue(1'b0, c, bb, {1'b0, ~ch, 1'b0, ap, col});
	endtask : access

	always @(posedge core_clk) begin
		if (acc_valid === 1'b1)
			chk("access", acc_q.size() ? acc_q.pop_front() : 32'hFFFFFFFF,
				{2'b00, acc_write, acc_bank, acc_row, acc_col, acc_chop,
				acc_autopre});
		if (store_valid === 1'b1)
			chk("beat", st_q.size() ? {24'h0, st_q.pop_front()} : 32'hFFFFFFFF,
				{24'h0, store_data});
		if (refresh_pulse === 1'b1)
			n_ref++;
	end

	initial begin
		#150000;
		n_fail++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, beat_valid, write_data_mask, beat_data} = 11'h0;
		{n_fail, check_count, n_ref} = 96'h0;
		rnd = 32'h374C129E;
		repeat (12) @(negedge core_clk);
		resetn = 1'b1;
		ctl.up();
		ctl.issue(1'b0, CMD_MRS, 3'h0, 14'h0001);
		ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0004);
		ctl.term_set(1'b1);
		chk("term", 32'h2, {term_on, tdqs_mode});
		rnd = lfsr(rnd);
		b = rnd[2:0];
		r = rnd[16:3];
		ctl.issue(1'b0, CMD_ACT, b, r);
		chk("bank_open", 32'h1 << b, bank_open);
		ctl.issue(1'b1, CMD_ACT, b + 3'h1, r);
		chk("bank_open", 32'h1 << b, bank_open);
		access(CMD_WR, 1'b0, 1'b0, b, r);
		chk("busy", 32'h1, wr_burst_busy);
		beats(10, 8, 2, 1'b1);
		chk("busy", 32'h0, wr_burst_busy);
		access(CMD_WR, 1'b1, 1'b0, b, r);
		beats(6, 4, 9, 1'b1);
		access(CMD_RD, 1'b0, 1'b1, b, r);
		chk("bank_open", 32'h0, bank_open);
		ctl.issue(1'b0, CMD_ACT, 3'h3, r);
		ctl.issue(1'b0, CMD_ACT, 3'h5, r);
		ctl.issue(1'b0, CMD_PRE, 3'h3, 14'h0000);
		chk("bank_open", 32'h20, bank_open);
		ctl.issue(1'b0, CMD_ACT, 3'h1, r);
		ctl.enter(CMD_NOP);
		chk("pwr_state", 32'h2, pwr_state);
		ctl.leave();
		chk("pwr_state", 32'h1, pwr_state);
		ctl.issue(1'b0, CMD_PRE, 3'h0, 14'h0400);
		chk("bank_open", 32'h0, bank_open);
		ctl.issue(1'b0, CMD_REF, 3'h0, 14'h0000);
		chk("refresh", 32'h1, n_ref);
		ctl.enter(CMD_NOP);
		chk("pwr_state", 32'h4, pwr_state);
		ctl.leave();
		ctl.enter(CMD_REF);
		chk("pwr_state", 32'h8, pwr_state);
		chk("sr_state", 32'h1, {cmd_buf_en, term_on, self_refresh});
		ctl.leave();
		chk("pwr_state", 32'h1, pwr_state);
		ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0804);
		chk("strobe", 32'h7, {term_on, term_strobe_on, tdqs_mode});
		ctl.issue(1'b0, CMD_ACT, b, r);
		access(CMD_WR, 1'b0, 1'b0, b, r);
		beats(8, 8, 0, 1'b0);
		ctl.issue(1'b0, CMD_MRS, 3'h1, 14'h0000);
		chk("term_on", 32'h0, term_on);
		ctl.issue(1'b0, CMD_MRS, 3'h5, 14'h0004);
		chk("term_on", 32'h0, term_on);
		ctl.issue(1'b0, CMD_MRS, 3'h2, 14'h0200);
		chk("term_on", 32'h1, term_on);
		ctl.issue(1'b0, CMD_MRS, 3'h0, 14'h0002);
		rnd = lfsr(rnd);
		acc_q.push_back({3'b001, b, r, rnd[9:0], 2'b10});
		ctl.issue(1'b0, CMD_WR, b, {4'h4, rnd[9:0]});
		beats(6, 4, 9, 1'b0);
		ctl.issue(1'b0, CMD_ACT, 3'h6, r);
		@(posedge core_clk);
		#0.5;
		ctl.pin(1'b0);
		#1;
		chk("pin_reset", 32'h1, {bank_open, pwr_state});
		ctl.pin(1'b1);
		chk("queues", 32'h0, acc_q.size() + st_q.size());
		test_done;
	end
endmodule : dca_cmd_front_tb
